// >>> rtl/ptq_pkg.sv
// pulse trigger qualifier: shared constants, offsets and enumerations
// assumes a 100 MHz core clock and an AHB-Lite register port
package ptq_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // auto timeout step at the fastest time base
  localparam int AUTO_BASE_NS  = 100000;
  localparam int AUTO_BASE_CYC = AUTO_BASE_NS / CLK_PERIOD_NS;
  // holdoff: one percent at the fastest time base
  localparam int HOLD_STEP_NS  = 1000;
  localparam int HOLD_STEP_CYC = HOLD_STEP_NS / CLK_PERIOD_NS;
  // peak search window for the half-level preset
  localparam int SEARCH_NS     = 50000;
  localparam int SEARCH_CYC    = SEARCH_NS / CLK_PERIOD_NS;

  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_GLITCH = 8'h04;
  localparam logic [7:0] A_WLO    = 8'h08;
  localparam logic [7:0] A_WHI    = 8'h0c;
  localparam logic [7:0] A_HOLD   = 8'h10;
  localparam logic [7:0] A_LEVEL  = 8'h14;
  localparam logic [7:0] A_THRESH = 8'h18;
  localparam logic [7:0] A_TBASE  = 8'h1c;
  localparam logic [7:0] A_STATUS = 8'h20;

  // control word fields; F_THI is the high byte of the threshold word
  localparam int F_CLASS  = 0;
  localparam int F_POL    = 2;
  localparam int F_REJECT = 4;
  localparam int F_OUTLIM = 5;
  localparam int F_NORMAL = 6;
  localparam int F_SRC    = 7;
  localparam int F_PRESET = 10;
  localparam int F_FORCE  = 12;
  localparam int F_THI    = 8;

  localparam logic [15:0] GLITCH_RST = 16'h0010;
  localparam logic [15:0] WLO_RST    = 16'h0008;
  localparam logic [15:0] WHI_RST    = 16'h0020;
  localparam logic [6:0]  HOLD_RST   = 7'h00;
  localparam logic [6:0]  HOLD_MAX   = 7'h64;
  localparam logic [7:0]  LEVEL_RST  = 8'h80;
  localparam logic [7:0]  THI_RST    = 8'hc0;
  localparam logic [7:0]  TLO_RST    = 8'h40;
  // logic-family switching thresholds in level codes
  localparam logic [7:0]  LVL_TTL    = 8'h8c;
  localparam logic [7:0]  LVL_ECL    = 8'h6a;

  localparam logic [1:0]  PRE_TTL    = 2'h1;
  localparam logic [1:0]  PRE_ECL    = 2'h2;
  localparam logic [1:0]  PRE_HALF   = 2'h3;

  typedef enum logic [1:0] {CL_GLITCH, CL_RUNT, CL_WIDTH} ptq_class_e;
  typedef enum logic [1:0] {POL_POS, POL_NEG, POL_EITHER} ptq_pol_e;
  typedef enum logic [1:0] {RS_IDLE, RS_UP, RS_DN} ptq_runt_e;

endpackage

// >>> rtl/ptq_sync.sv
// two-flop synchroniser with edge flags for comparator pins
// assumes inputs are asynchronous to core_clk_i
`timescale 1ns/1ns
`default_nettype none
module ptq_sync #(
  parameter int W = 18
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } ptq_sync_s;

  ptq_sync_s s;
  ptq_sync_s next_s;

  always_comb
  begin
    next_s      = s;
    next_s.meta = async_i;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      s <= '0;
    else
      s <= next_s;
  end

  // edges look only at the second and third stages
  assign level_o = s.sync;
  assign rise_o  = s.sync & ~s.prev;
  assign fall_o  = ~s.sync & s.prev;
endmodule
`default_nettype wire

// >>> rtl/ptq_top.sv
// pulse trigger qualifier: glitch, runt and width classes, mode, holdoff
// assumes comparator pins per source and ADC samples on core_clk_i
//
// Summary of operation
// R1: glitch accept triggers only on pulses narrower than glitch width
// R2: glitch reject triggers only on pulses wider than glitch width
// R3: glitch polarity picks positive, negative or both pulse directions
// R4: positive runt: lower crossed up, recrossed down, upper never crossed
// R5: negative runt: upper crossed down, recrossed up, lower never crossed
// R6: either runt: either threshold crossed, recrossed, other untouched
// R7: runt trigger falls on the recross of the first threshold
// R8: runt uses two user-set thresholds, high and low
// R9: width class offers only positive or negative polarity
// R10: within-limits width triggers on widths inside lower..upper
// R11: out-of-limits width triggers on widths outside lower..upper
// R12: upper limit is largest valid width, lower the smallest
// R13: lower width limit is kept at or below the upper limit
// R14: auto mode acquires after a time-base dependent timeout
// R15: normal mode acquires only on a valid trigger
// R16: a forced trigger yields exactly one acquisition
// R17: holdoff in percent blocks triggers after an acquisition
// R18: source selector routes exactly one channel to the trigger
// R19: half-level preset sets level midway between signal peaks
// R20: logic-family presets set level to that family's threshold
// R21: glitch either triggers on short pulses of both polarities
// R22: widths are counted in clock cycles against cycle limits
`timescale 1ns/1ns
`default_nettype none
module ptq_top #(
  parameter bit TWO_CH     = 1'b0,
  parameter int AUTO_CYC   = ptq_pkg::AUTO_BASE_CYC,
  parameter int SEARCH_LEN = ptq_pkg::SEARCH_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [5:0]  lvl_cmp_i,
  input  wire logic [5:0]  hi_cmp_i,
  input  wire logic [5:0]  lo_cmp_i,
  input  wire logic [47:0] sample_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             acq_start_o,
  output logic             trig_o,
  output logic      [7:0]  level_o,
  output logic      [7:0]  thr_hi_o,
  output logic      [7:0]  thr_lo_o
);
  import ptq_pkg::*;

  if (AUTO_CYC < 1 || AUTO_CYC > 131071 || SEARCH_LEN < 1)
    $error("ptq_top: counts out of range");

  typedef struct packed {
    ptq_class_e  cls;
    ptq_pol_e    pol;
    logic        rej;
    logic        outl;
    logic        norm;
    logic [1:0]  src;
    logic [15:0] gw;
    logic [15:0] wlo;
    logic [15:0] whi;
    logic [6:0]  hold;
    logic [3:0]  tb;
    logic [7:0]  lvl;
    logic [7:0]  thi;
    logic [7:0]  tlo;
    logic        force_pend;
    logic        srch;
    logic [31:0] scnt;
    logic [7:0]  pmax;
    logic [7:0]  pmin;
    logic [15:0] wcnt;
    logic [15:0] tw;
    logic        seen;
    ptq_runt_e   rs;
    logic [31:0] hcnt;
    logic [31:0] acnt;
    logic [15:0] nacq;
    logic        acq;
    logic        trig;
    logic        a_ok;
    logic        a_wr;
    logic [7:0]  a_adr;
    logic        rdy;
    logic [31:0] rdata;
  } ptq_state_s;

  ptq_state_s s;
  ptq_state_s next_s;

  logic [17:0] c_lv;
  logic [17:0] c_r;
  logic [17:0] c_f;

  ptq_sync #(.W(18)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    ({lo_cmp_i, hi_cmp_i, lvl_cmp_i}),
    .level_o    (c_lv),
    .rise_o     (c_r),
    .fall_o     (c_f)
  );

  // two-channel build swaps channels three and four for the aux inputs
  function automatic logic [2:0] src_idx(input logic [1:0] code);
    if (TWO_CH && code[1])
      return {2'b10, code[0]};
    return {1'b0, code};
  endfunction

  function automatic logic [31:0] rd_reg(input ptq_state_s r, input logic [7:0] a);
    unique case (a)
      A_CTRL:   rd_reg = {23'h0, r.src, r.norm, r.outl, r.rej, r.pol, r.cls};
      A_GLITCH: rd_reg = {16'h0, r.gw};
      A_WLO:    rd_reg = {16'h0, r.wlo};
      A_WHI:    rd_reg = {16'h0, r.whi};
      A_HOLD:   rd_reg = {25'h0, r.hold};
      A_LEVEL:  rd_reg = {24'h0, r.lvl};
      A_THRESH: rd_reg = {16'h0, r.thi, r.tlo};
      A_TBASE:  rd_reg = {28'h0, r.tb};
      A_STATUS: rd_reg = {r.nacq, 10'h0, r.rs, r.force_pend, r.srch,
                          1'b0, r.hcnt != 32'h0};
      default:  rd_reg = 32'h0;
    endcase
  endfunction

  logic [2:0]  si;
  logic        lv_r;
  logic        lv_f;
  logic        hi_lv;
  logic        hi_r;
  logic        hi_f;
  logic        lo_r;
  logic        lo_f;
  logic [7:0]  smp;
  logic        pos_end;
  logic        neg_end;
  logic        g_hit;
  logic        w_hit;
  logic        r_hit;
  logic        qual;
  logic        w_in;
  logic [31:0] tmo;
  logic [31:0] hload;
  logic [8:0]  psum;
  logic [15:0] wd;

  always_comb
  begin
    next_s      = s;
    next_s.acq  = 1'b0;
    next_s.trig = 1'b0;
    wd          = hwdata_i[15:0];
    r_hit       = 1'b0;

    // source routing
    si    = src_idx(s.src); // R18
    lv_r  = c_r[si];
    lv_f  = c_f[si];
    hi_lv = c_lv[6 + si];
    hi_r  = c_r[6 + si];
    hi_f  = c_f[6 + si];
    lo_r  = c_r[12 + si];
    lo_f  = c_f[12 + si];
    smp   = sample_i[8*si +: 8];

    // register writes land in the data phase
    if (s.a_ok && s.a_wr)
    begin
      unique case (s.a_adr)
        A_CTRL:
        begin
          if (hwdata_i[F_CLASS +: 2] != 2'h3)
            next_s.cls = ptq_class_e'(hwdata_i[F_CLASS +: 2]);
          next_s.pol = (hwdata_i[F_POL +: 2] == 2'h3) ? POL_EITHER
                     : ptq_pol_e'(hwdata_i[F_POL +: 2]); // R3
          if (next_s.cls == CL_WIDTH && next_s.pol == POL_EITHER)
            next_s.pol = POL_POS; // R9
          next_s.rej  = hwdata_i[F_REJECT];
          next_s.outl = hwdata_i[F_OUTLIM];
          next_s.norm = hwdata_i[F_NORMAL];
          next_s.src  = hwdata_i[F_SRC +: 2];
          unique case (hwdata_i[F_PRESET +: 2])
            PRE_TTL:  next_s.lvl = LVL_TTL; // R20
            PRE_ECL:  next_s.lvl = LVL_ECL; // R20
            PRE_HALF:
            begin
              next_s.srch = 1'b1; // R19
              next_s.scnt = 32'(SEARCH_LEN);
              next_s.pmax = 8'h00;
              next_s.pmin = 8'hff;
            end
            default: ;
          endcase
          if (hwdata_i[F_FORCE])
            next_s.force_pend = 1'b1; // R16
        end
        A_GLITCH: next_s.gw = wd;
        A_WLO:    next_s.wlo = (wd > s.whi) ? s.whi : wd; // R13
        A_WHI:
        begin
          next_s.whi = wd; // R12
          if (s.wlo > wd)
            next_s.wlo = wd; // R13
        end
        A_HOLD:   next_s.hold = (hwdata_i[6:0] > HOLD_MAX) ? HOLD_MAX : hwdata_i[6:0]; // R17
        A_LEVEL:  next_s.lvl = hwdata_i[7:0];
        A_THRESH:
        begin
          next_s.thi = hwdata_i[F_THI +: 8]; // R8
          next_s.tlo = hwdata_i[7:0]; // R8
        end
        A_TBASE:  next_s.tb = hwdata_i[3:0];
        default: ;
      endcase
    end

    // reads take one wait state so a preceding write is visible
    next_s.rdy   = 1'b1;
    next_s.a_ok  = hsel_i & htrans_i[1] & hready_i;
    next_s.a_wr  = hwrite_i;
    next_s.a_adr = haddr_i[7:0];
    if (next_s.a_ok && !hwrite_i)
      next_s.rdy = 1'b0;
    if (s.a_ok && !s.a_wr)
      next_s.rdata = rd_reg(s, s.a_adr);

    // half-level peak search on the routed source
    if (s.srch)
    begin
      if (smp > s.pmax)
        next_s.pmax = smp;
      if (smp < s.pmin)
        next_s.pmin = smp;
      next_s.scnt = s.scnt - 32'h1;
      if (s.scnt == 32'h1)
      begin
        psum        = {1'b0, next_s.pmax} + {1'b0, next_s.pmin};
        next_s.lvl  = psum[8:1]; // R19
        next_s.srch = 1'b0;
      end
    end
    psum = {1'b0, s.pmax} + {1'b0, s.pmin};

    // width counter restarts on every level edge
    if (lv_r || lv_f)
    begin
      next_s.wcnt = 16'h1; // R22
      next_s.seen = 1'b1;
    end
    else if (s.wcnt != 16'hffff)
      next_s.wcnt = s.wcnt + 16'h1; // R22
    // a pulse only counts once its leading edge was seen
    pos_end = lv_f & s.seen;
    neg_end = lv_r & s.seen;

    unique case (s.pol)
      POL_POS:    g_hit = pos_end; // R3
      POL_NEG:    g_hit = neg_end; // R3
      POL_EITHER: g_hit = pos_end | neg_end; // R21
      default:    g_hit = 1'b0;
    endcase
    g_hit = g_hit & (s.rej ? (s.wcnt > s.gw) : (s.wcnt < s.gw)); // R1 R2

    w_in  = (s.wcnt >= s.wlo) && (s.wcnt <= s.whi); // R12
    w_hit = ((s.pol == POL_NEG) ? neg_end : pos_end) & (w_in ^ s.outl); // R10 R11

    unique case (s.rs)
      RS_IDLE:
      begin
        if (s.pol != POL_NEG && lo_r && !hi_lv)
          next_s.rs = RS_UP; // R4 R6
        // lower must still be high, else the swing crossed both at once
        else if (s.pol != POL_POS && hi_f && c_lv[12 + si])
          next_s.rs = RS_DN; // R5 R6
      end
      RS_UP:
      begin
        if (hi_r)
          next_s.rs = RS_IDLE; // R4
        else if (lo_f)
        begin
          r_hit     = 1'b1; // R7
          next_s.rs = RS_IDLE;
        end
      end
      RS_DN:
      begin
        if (lo_f)
          next_s.rs = RS_IDLE; // R5
        else if (hi_r)
        begin
          r_hit     = 1'b1; // R7
          next_s.rs = RS_IDLE;
        end
      end
    endcase
    if (s.cls != CL_RUNT)
      next_s.rs = RS_IDLE;

    qual = (s.cls == CL_GLITCH) ? g_hit
         : (s.cls == CL_RUNT) ? r_hit : w_hit;

    // slower time bases stretch both the auto wait and the holdoff
    tmo   = 32'(AUTO_CYC) << s.tb; // R14
    hload = (32'(s.hold) * 32'(HOLD_STEP_CYC)) << s.tb; // R17

    if (s.hcnt != 32'h0)
      next_s.hcnt = s.hcnt - 32'h1; // R17
    else if (qual || s.force_pend || (!s.norm && s.acnt >= tmo)) // R14 R15
    begin
      next_s.acq        = 1'b1;
      next_s.trig       = qual;
      next_s.tw         = s.wcnt;
      next_s.force_pend = 1'b0; // R16
      next_s.hcnt       = hload; // R17
      next_s.acnt       = 32'h0;
      next_s.nacq       = s.nacq + 16'h1;
    end
    else if (!s.norm)
      next_s.acnt = s.acnt + 32'h1; // R14
    if (s.a_ok && s.a_wr && s.a_adr == A_CTRL && hwdata_i[F_FORCE])
      next_s.force_pend = 1'b1; // R16
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s      <= '0;
      s.gw   <= GLITCH_RST;
      s.wlo  <= WLO_RST;
      s.whi  <= WHI_RST;
      s.hold <= HOLD_RST;
      s.lvl  <= LEVEL_RST;
      s.thi  <= THI_RST;
      s.tlo  <= TLO_RST;
      s.pmin <= 8'hff;
      s.rdy  <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign hrdata_o    = s.rdata;
  assign hreadyout_o = s.rdy;
  assign hresp_o     = 1'b0;
  assign acq_start_o = s.acq;
  assign trig_o      = s.trig;
  assign level_o     = s.lvl;
  assign thr_hi_o    = s.thi;
  assign thr_lo_o    = s.tlo;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  chk_glitch_accept: assert property ( // R1
    s.trig && s.cls == CL_GLITCH && !s.rej && $stable(s.gw) |-> s.tw < s.gw)
    else $error("accepted glitch not narrower than limit");
  chk_glitch_reject: assert property ( // R2
    s.trig && s.cls == CL_GLITCH && s.rej && $stable(s.gw) |-> s.tw > s.gw)
    else $error("rejected glitch trigger not wider than limit");
  chk_width_range: assert property ( // R10
    s.trig && s.cls == CL_WIDTH && $stable(s.wlo) && $stable(s.whi)
    |-> ((s.tw >= s.wlo && s.tw <= s.whi) != s.outl))
    else $error("width trigger disagrees with limit option");
  chk_limit_order: assert property (s.wlo <= s.whi) // R13
    else $error("lower width limit above upper");
  chk_width_pol: assert property (!(s.cls == CL_WIDTH && s.pol == POL_EITHER)) // R9
    else $error("width class with either polarity");
  chk_runt_point: assert property ( // R7
    s.trig && s.cls == CL_RUNT && $past(s.cls) == CL_RUNT |-> $past(s.rs) != RS_IDLE)
    else $error("runt trigger without a first crossing");
  chk_normal_only: assert property ( // R15
    s.acq && s.norm && $past(s.norm) |-> s.trig || $past(s.force_pend))
    else $error("normal mode acquired without trigger");
  chk_force_once: assert property ( // R16
    s.force_pend && s.hcnt == 32'h0 |=> s.acq ##1 !s.acq)
    else $error("forced trigger not a single acquisition");
  chk_holdoff_block: assert property ( // R17
    s.hcnt > 32'h1 |=> !s.acq [*1] ##0 s.hcnt == $past(s.hcnt) - 32'h1)
    else $error("acquisition during holdoff");
  chk_auto_tmo: assert property ( // R14
    !s.norm && s.hcnt == 32'h0 && s.acnt >= tmo |=> s.acq && s.acnt == 32'h0)
    else $error("auto timeout did not acquire");
endmodule
`default_nettype wire

// >>> tb/ptq_cmp_model.sv
// comparator bank model: per-source analog values against device levels
// assumes the bench changes values just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module ptq_cmp_model (
  input  wire logic [47:0] ana_i,
  input  wire logic [7:0]  level_i,
  input  wire logic [7:0]  thr_hi_i,
  input  wire logic [7:0]  thr_lo_i,
  output logic      [5:0]  lvl_cmp_o,
  output logic      [5:0]  hi_cmp_o,
  output logic      [5:0]  lo_cmp_o,
  output logic      [47:0] sample_o
);
  always_comb
  begin
    sample_o = ana_i;
    for (int k = 0; k < 6; k++)
    begin
      // equal to a level reads as below, like a comparator with no hysteresis
      lvl_cmp_o[k] = ana_i[k*8 +: 8] > level_i;
      hi_cmp_o[k]  = ana_i[k*8 +: 8] > thr_hi_i;
      lo_cmp_o[k]  = ana_i[k*8 +: 8] > thr_lo_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb/pulse_trigger_qualifier_test.sv
// self-checking bench for the pulse trigger qualifier
// assumes the comparator model on the pins and a single AHB-Lite master
`timescale 1ns/1ns
`default_nettype none
module pulse_trigger_qualifier_test;
  import ptq_pkg::*;
  localparam int AUTO_T = 20;
  localparam int SRCH_T = 16;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0]  base;
    logic [7:0]  peak;
    logic [7:0]  wid;
    logic        trig;
  } ptq_row_s;
  ptq_row_s    rows [21] = '{
    '{16'h40, 8'h00, 8'hff, 8'd8, 1'b1}, '{16'h40, 8'h00, 8'hff, 8'd16, 1'b0},
    '{16'h40, 8'hff, 8'h00, 8'd8, 1'b0}, '{16'h44, 8'hff, 8'h00, 8'd8, 1'b1},
    '{16'h48, 8'hff, 8'h00, 8'd8, 1'b1}, '{16'h48, 8'h00, 8'hff, 8'd8, 1'b1},
    '{16'h50, 8'h00, 8'hff, 8'd24, 1'b1}, '{16'h50, 8'h00, 8'hff, 8'd8, 1'b0},
    '{16'h41, 8'h00, 8'h60, 8'd8, 1'b1}, '{16'h41, 8'h00, 8'hff, 8'd8, 1'b0},
    '{16'h45, 8'hff, 8'ha0, 8'd8, 1'b1}, '{16'h45, 8'hff, 8'h00, 8'd8, 1'b0},
    '{16'h49, 8'h00, 8'h60, 8'd8, 1'b1}, '{16'h49, 8'hff, 8'ha0, 8'd8, 1'b1},
    '{16'h42, 8'h00, 8'hff, 8'd7, 1'b0}, '{16'h42, 8'h00, 8'hff, 8'd8, 1'b1},
    '{16'h42, 8'h00, 8'hff, 8'd32, 1'b1}, '{16'h42, 8'h00, 8'hff, 8'd33, 1'b0},
    '{16'h62, 8'h00, 8'hff, 8'd40, 1'b1}, '{16'h62, 8'h00, 8'hff, 8'd20, 1'b0},
    '{16'h46, 8'hff, 8'h00, 8'd20, 1'b1}};
  logic [7:0]  ra [9] = '{A_CTRL, A_GLITCH, A_WLO, A_WHI, A_HOLD, A_LEVEL, A_THRESH, A_TBASE,
                          8'h24};
  logic [31:0] rv [9] = '{32'h0, {16'h0, GLITCH_RST}, {16'h0, WLO_RST}, {16'h0, WHI_RST},
                          {25'h0, HOLD_RST}, {24'h0, LEVEL_RST}, {16'h0, THI_RST, TLO_RST},
                          32'h0, 32'h0};
  logic        core_clk_i = 1'b0;
  logic        reset_i    = 1'b1;
  logic [47:0] ana        = '0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = '0;
  logic [1:0]  htrans     = 2'b00;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = '0;
  logic [5:0]  lvl_cmp;
  logic [5:0]  hi_cmp;
  logic [5:0]  lo_cmp;
  logic [47:0] sample;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        acq_start;
  logic        trig;
  logic [7:0]  level;
  logic [7:0]  thr_hi;
  logic [7:0]  thr_lo;
  int          failures    = 0;
  int          check_count = 0;
  int          cnt;
  int          ofs;
  int          acq;
  int          trg;

  ptq_cmp_model u_ptq_cmp_model (.ana_i(ana), .level_i(level), .thr_hi_i(thr_hi),
    .thr_lo_i(thr_lo), .lvl_cmp_o(lvl_cmp), .hi_cmp_o(hi_cmp), .lo_cmp_o(lo_cmp),
    .sample_o(sample));
  ptq_top #(.TWO_CH(1'b0), .AUTO_CYC(AUTO_T), .SEARCH_LEN(SRCH_T)) u_ptq_top (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .lvl_cmp_i(lvl_cmp), .hi_cmp_i(hi_cmp),
    .lo_cmp_i(lo_cmp), .sample_i(sample), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .acq_start_o(acq_start), .trig_o(trig), .level_o(level), .thr_hi_o(thr_hi),
    .thr_lo_o(thr_lo));

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bound for every handshake wait, so a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge core_clk_i);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge core_clk_i);
    end
    if (n >= 20)
    begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(nm, exp, r);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic watch(input int n, output int a, output int t);
    a = 0;
    t = 0;
    repeat (n)
    begin
      @(posedge core_clk_i);
      a += int'(acq_start === 1'b1);
      t += int'(trig === 1'b1);
    end
  endtask

  task automatic pulse(input int s, input logic [7:0] b, input logic [7:0] p, input int w,
                       output int c, output int o);
    c = 0;
    o = -99;
    @(posedge core_clk_i);
    ana[s*8 +: 8] <= p;
    for (int i = 1; i <= w + 14; i++)
    begin
      @(posedge core_clk_i);
      if (i == w)
        ana[s*8 +: 8] <= b;
      if (acq_start !== trig)
        check("acq_start with trig", {31'h0, trig}, {31'h0, acq_start});
      if (trig === 1'b1)
      begin
        c++;
        if (o == -99)
          o = i - w;
      end
    end
  endtask

  task automatic next_acq(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (acq_start !== 1'b1 && n < 300);
    if (acq_start !== 1'b1)
    begin
      failures++;
      print_verdict();
    end
  endtask

  initial
  begin
    #900000;
    failures++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge core_clk_i);
    check("reset outputs", {LEVEL_RST, THI_RST, TLO_RST, 8'h80},
          {level, thr_hi, thr_lo, hreadyout, acq_start, trig, 5'h0});
    reset_i <= 1'b0;
    wr(8'h24, 32'hffffffff);
    for (int k = 0; k < 9; k++)
      rdc("register reset", ra[k], rv[k]);
    for (int k = 0; k < 21; k++)
    begin
      @(posedge core_clk_i);
      ana[7:0] <= rows[k].base;
      repeat (30) @(posedge core_clk_i);
      wr(A_CTRL, {16'h0, rows[k].ctrl});
      pulse(0, rows[k].base, rows[k].peak, int'(rows[k].wid), cnt, ofs);
      check("trigger count", {31'h0, rows[k].trig}, cnt);
      if (rows[k].trig)
        check("trigger delay", 32'h1, {31'h0, ofs >= 3 && ofs <= 5});
    end
    wr(A_CTRL, 32'h140);
    pulse(0, 8'h00, 8'hff, 8, cnt, ofs);
    check("unselected source", 32'h0, cnt);
    pulse(2, 8'h00, 8'hff, 8, cnt, ofs);
    check("selected source", 32'h1, cnt);
    wr(A_HOLD, 32'h1);
    wr(A_CTRL, 32'h40);
    watch(60, acq, trg);
    check("normal idle acq", 32'h0, acq);
    wr(A_CTRL, 32'h1040);
    watch(30, acq, trg);
    check("forced acq", 32'h1, acq);
    check("forced trig", 32'h0, trg);
    wr(A_CTRL, 32'h1040);
    watch(40, acq, trg);
    check("force in holdoff", 32'h0, acq);
    watch(100, acq, trg);
    check("force after holdoff", 32'h1, acq);
    wr(A_HOLD, 32'hff);
    rdc("holdoff clamp", A_HOLD, {25'h0, HOLD_MAX});
    wr(A_HOLD, 32'h0);
    wr(A_WLO, 32'h40);
    rdc("lower over upper", A_WLO, {16'h0, WHI_RST});
    wr(A_WHI, 32'h4);
    rdc("upper under lower", A_WLO, 32'h4);
    for (int tb = 0; tb < 2; tb++)
    begin
      wr(A_TBASE, tb);
      wr(A_CTRL, 32'h0);
      next_acq(cnt);
      next_acq(cnt);
      check("auto timeout", 32'h1, {31'h0, cnt >= (AUTO_T << tb) && cnt <= (AUTO_T << tb) + 1});
    end
    wr(A_CTRL, 32'h440);
    repeat (3) @(posedge core_clk_i);
    check("ttl level", {24'h0, LVL_TTL}, {24'h0, level});
    wr(A_CTRL, 32'h840);
    repeat (3) @(posedge core_clk_i);
    check("ecl level", {24'h0, LVL_ECL}, {24'h0, level});
    // the search samples from the write onward, so the low peak stands first
    ana[7:0] <= 8'h10;
    wr(A_CTRL, 32'hc40);
    for (int i = 0; i < 4 * SRCH_T; i++)
    begin
      @(posedge core_clk_i);
      ana[7:0] <= (i % 2 == 1) ? 8'hd0 : 8'h10;
    end
    // midway between peaks 8'h10 and 8'hd0
    check("half level", 32'h70, {24'h0, level});
    wr(A_THRESH, 32'hb030);
    repeat (3) @(posedge core_clk_i);
    check("runt thresholds", 32'hb030, {16'h0, thr_hi, thr_lo});
    print_verdict();
  end
endmodule
`default_nettype wire
